// *** hw/frtf_top.sv ***
// Fault and warning reporting with latch selection, overcurrent monitoring and thermal gain foldback.
// Function
// - Status bits 7..4 show channel overcurrent faults.
// - Status bits 3..0 show channel overcurrent warnings.
// - Bit 6 latches overtemperature fault report.
// - Bit 5 latches overcurrent fault report.
// - Bit 4 latches core undervoltage warning report.
// - Bit 3 latches core power-on-reset warning report.
// - Bit 2 latches overtemperature warning report.
// - Bit 1 latches overcurrent warning report.
// - Bit 0 latches clip report.
// - Pin control bit 7 reads zero, unwritable.
// - Wait zero crossing up to timeout, then change.
// - Foldback bit 5 set disables foldback.
// - Foldback bit 4 set skips zero crossing.
// - Attack field picks 100 to 800 ms/dB.
// - Release field picks 200 to 1600 ms/dB.
// - Dense current limiting warns; persistence faults, Hi-Z.
// - Writing clear bit clears latched reports.
`include "frtf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module frtf_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter int CHANNELS = 4,
  parameter int MAX_ATTEN = 24,
  parameter int OC_WINDOW_CYC = `FRTF_OC_WINDOW_MS * 1000 * `FRTF_CLK_MHZ,
  parameter int ATK_BASE_CYC = `FRTF_ATK_BASE_MS * 1000 * `FRTF_CLK_MHZ,
  parameter int REL_BASE_CYC = `FRTF_REL_BASE_MS * 1000 * `FRTF_CLK_MHZ,
  parameter int ZC_BASE_CYC = `FRTF_ZC_BASE_US * `FRTF_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [CHANNELS-1:0] oc_limit_flag,
  input wire logic zero_cross,
  input wire frtf_pkg::frtf_cond_s cond,
  output frtf_pkg::frtf_report_s report,
  output logic [5:0] gain_atten_db
);
  import frtf_pkg::*;

  localparam int OC_THR = OC_WINDOW_CYC / 100 * `FRTF_OC_DENSITY_PCT;

  logic [7:0] misc_r, pin_ctl_r, fb_ctl_r;
  logic scl_q, sda_q, drv_low_r, rw_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, rd_cur;
  frtf_i2c_e i2c_st_r;
  logic scl_rise, scl_fall, bus_start, bus_stop, wr_stb, clear_pulse;

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] st);
    case (a)
      `FRTF_ADDR_MISC: rd_byte = misc_r;
      `FRTF_ADDR_OCSTAT: rd_byte = st;
      `FRTF_ADDR_PINCTL: rd_byte = pin_ctl_r;
      `FRTF_ADDR_FBCTL: rd_byte = fb_ctl_r;
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // Bus pins are taken as already synchronous; one stage only gives edge detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
  assign bus_stop = scl_i & scl_q & ~sda_q & sda_i;
  assign wr_stb = (i2c_st_r == I2C_WDAT) && scl_fall && (bit_cnt_r == 4'h8);
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drv_low_r;

  logic [CHANNELS-1:0] oc_warn, oc_fault;
  // A process rather than an assign, so that a register write alone also refreshes the read byte.
  always_comb rd_cur = rd_byte(ptr_r, {oc_fault[3:0], oc_warn[3:0]});

  always_ff @(posedge clk) begin
    if (rst) begin
      i2c_st_r <= I2C_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      drv_low_r <= 1'b0;
    end else if (bus_start) begin
      i2c_st_r <= I2C_ADDR;
      bit_cnt_r <= 4'h0;
      drv_low_r <= 1'b0;
    end else if (bus_stop) begin
      i2c_st_r <= I2C_IDLE;
      drv_low_r <= 1'b0;
    end else begin
      case (i2c_st_r)
        I2C_ADDR, I2C_REG, I2C_WDAT: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_i};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            drv_low_r <= 1'b1;
            if (i2c_st_r == I2C_ADDR) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                rw_r <= sh_r[0];
                i2c_st_r <= I2C_AACK;
              end else begin
                drv_low_r <= 1'b0;
                i2c_st_r <= I2C_IDLE;
              end
            end else if (i2c_st_r == I2C_REG) begin
              ptr_r <= sh_r;
              i2c_st_r <= I2C_RACK;
            end else begin
              i2c_st_r <= I2C_WACK;
            end
          end
        end
        I2C_AACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              tx_r <= rd_cur;
              drv_low_r <= ~rd_cur[7];
              i2c_st_r <= I2C_TX;
            end else begin
              drv_low_r <= 1'b0;
              i2c_st_r <= I2C_REG;
            end
          end
        end
        I2C_RACK, I2C_WACK: begin
          if (scl_fall) begin
            drv_low_r <= 1'b0;
            i2c_st_r <= I2C_WDAT;
            if (i2c_st_r == I2C_WACK) begin
              ptr_r <= ptr_r + 8'h01;
            end
          end
        end
        I2C_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              bit_cnt_r <= 4'h0;
              drv_low_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
              i2c_st_r <= I2C_TXACK;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              tx_r <= {tx_r[6:0], 1'b0};
              drv_low_r <= ~tx_r[6];
            end
          end
        end
        I2C_TXACK: begin
          if (scl_rise && sda_i) begin
            i2c_st_r <= I2C_IDLE;
          end else if (scl_fall) begin
            tx_r <= rd_cur;
            drv_low_r <= ~rd_cur[7];
            i2c_st_r <= I2C_TX;
          end
        end
        default: i2c_st_r <= I2C_IDLE;
      endcase
    end
  end

  // The clear bit is a command, so it drops back to zero the cycle after the write.
  always_ff @(posedge clk) begin
    if (rst) begin
      misc_r <= `FRTF_MISC_RST;
      pin_ctl_r <= `FRTF_PINCTL_RST;
      fb_ctl_r <= `FRTF_FBCTL_RST;
    end else begin
      misc_r[`FRTF_MISC_CLR_BIT] <= 1'b0;
      if (wr_stb && ptr_r == `FRTF_ADDR_MISC) begin
        misc_r[`FRTF_MISC_CLR_BIT] <= sh_r[`FRTF_MISC_CLR_BIT];
        misc_r[`FRTF_MISC_MASK_BIT] <= sh_r[`FRTF_MISC_MASK_BIT];
      end
      if (wr_stb && ptr_r == `FRTF_ADDR_PINCTL) begin
        pin_ctl_r <= {1'b0, sh_r[6:0]};
      end
      if (wr_stb && ptr_r == `FRTF_ADDR_FBCTL) begin
        fb_ctl_r <= sh_r;
      end
    end
  end

  assign clear_pulse = misc_r[`FRTF_MISC_CLR_BIT];

  logic [31:0] win_cnt_r;
  logic win_end;
  assign win_end = (win_cnt_r == 32'(OC_WINDOW_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst || win_end) begin
      win_cnt_r <= 32'h0;
    end else begin
      win_cnt_r <= win_cnt_r + 32'h1;
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : g_oc
    logic [31:0] dens_r;
    logic [2:0] pers_r;
    logic warn_r;
    always_ff @(posedge clk) begin
      if (rst) begin
        dens_r <= 32'h0;
        pers_r <= 3'h0;
        warn_r <= 1'b0;
      end else if (win_end) begin
        dens_r <= 32'h0;
        warn_r <= dens_r > 32'(OC_THR);
        if (dens_r <= 32'(OC_THR)) begin
          pers_r <= 3'h0;
        end else if (warn_r && pers_r != 3'(`FRTF_OC_PERSIST_WIN)) begin
          pers_r <= pers_r + 3'h1;
        end
      end else if (oc_limit_flag[g]) begin
        dens_r <= dens_r + 32'h1;
      end
    end
    assign oc_warn[g] = warn_r;
    // A fault needs a warning window followed by four more that still exceed the density.
    assign oc_fault[g] = (pers_r == 3'(`FRTF_OC_PERSIST_WIN));
  end

  logic [6:0] live, hold_r, rep;
  assign live = {cond.ot_fault, |oc_fault, cond.core_uv, cond.core_por, cond.ot_warn,
                 |oc_warn & ~misc_r[`FRTF_MISC_MASK_BIT], cond.clip};

  // Set beats clear so an event landing on the clear cycle survives.
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= 7'h00;
    end else begin
      hold_r <= (hold_r & ~{7{clear_pulse}}) | live;
    end
  end

  assign rep = (pin_ctl_r[6:0] & hold_r) | live;

  always_ff @(posedge clk) begin
    if (rst) begin
      report <= '0;
    end else begin
      report.fault_pin <= rep[6] | rep[5];
      report.warn_pin <= |rep[4:1];
      report.clip_pin <= rep[0];
      report.channels_hiz <= rep[5];
    end
  end

  frtf_fb_e fb_st_r;
  logic [31:0] step_cnt_r, zc_cnt_r, step_lim, zc_lim;
  logic dir_up_r, step_due, fb_off, zc_skip;
  logic [1:0] atk, rel, zc_sel;
  assign atk = fb_ctl_r[`FRTF_FB_ATK_MSB:`FRTF_FB_ATK_LSB];
  assign rel = fb_ctl_r[`FRTF_FB_REL_MSB:`FRTF_FB_REL_LSB];
  assign zc_sel = fb_ctl_r[`FRTF_FB_ZC_MSB:`FRTF_FB_ZC_LSB];
  assign fb_off = fb_ctl_r[`FRTF_FB_BYPASS_BIT];
  assign zc_skip = fb_ctl_r[`FRTF_FB_ZCSKIP_BIT];
  assign step_lim = cond.thermal ? (32'(ATK_BASE_CYC) << atk) : (32'(REL_BASE_CYC) << rel);
  assign zc_lim = 32'(ZC_BASE_CYC) << {zc_sel, 1'b0};
  assign step_due = cond.thermal ? (gain_atten_db < 6'(MAX_ATTEN)) : (gain_atten_db != 6'h00);

  // The step timer restarts while no step is due, so the first step after onset takes a full period.
  always_ff @(posedge clk) begin
    if (rst || fb_off) begin
      fb_st_r <= FB_IDLE;
      step_cnt_r <= 32'h0;
      zc_cnt_r <= 32'h0;
      dir_up_r <= 1'b0;
      gain_atten_db <= 6'h00;
    end else begin
      case (fb_st_r)
        FB_IDLE: begin
          if (!step_due || fb_st_r != FB_IDLE) begin
            step_cnt_r <= 32'h0;
          end else if (step_cnt_r >= step_lim - 32'h1) begin
            step_cnt_r <= 32'h0;
            if (zc_skip) begin
              gain_atten_db <= cond.thermal ? gain_atten_db + 6'h01 : gain_atten_db - 6'h01;
            end else begin
              dir_up_r <= cond.thermal;
              zc_cnt_r <= 32'h0;
              fb_st_r <= FB_WAIT_ZC;
            end
          end else begin
            step_cnt_r <= step_cnt_r + 32'h1;
          end
        end
        FB_WAIT_ZC: begin
          zc_cnt_r <= zc_cnt_r + 32'h1;
          if (zero_cross || zc_cnt_r >= zc_lim - 32'h1) begin
            gain_atten_db <= dir_up_r ? gain_atten_db + 6'h01 : gain_atten_db - 6'h01;
            fb_st_r <= FB_IDLE;
          end
        end
        default: fb_st_r <= FB_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pin_rsv;
    $past(wr_stb) |-> !pin_ctl_r[`FRTF_PIN_RSV_BIT];
  endproperty
  a_pin_rsv: assert property (p_pin_rsv) else $error("reserved pin control bit set");
  property p_ot_hold;
    pin_ctl_r[6] && report.fault_pin && !cond.ot_fault && !clear_pulse && hold_r[6] ##1 !clear_pulse |=> report.fault_pin;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("latched fault report dropped");
  property p_unlatched_follow;
    !pin_ctl_r[0] && !cond.clip |=> !report.clip_pin;
  endproperty
  a_unlatched_follow: assert property (p_unlatched_follow) else $error("unlatched clip report held");
  property p_clear;
    clear_pulse && live == 7'h00 |=> hold_r == 7'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a report held");
  property p_bypass;
    fb_off |=> gain_atten_db == 6'h00 && fb_st_r == FB_IDLE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("gain moved while foldback disabled");
  // A shorter timeout written in mid-wait ends the wait on the very next edge instead.
  property p_zc_bound;
    fb_st_r == FB_WAIT_ZC && $stable(zc_sel) |-> zc_cnt_r < zc_lim;
  endproperty
  a_zc_bound: assert property (p_zc_bound) else $error("zero crossing wait overran");
  property p_attack;
    fb_st_r == FB_WAIT_ZC && dir_up_r && zero_cross && !fb_off |=> gain_atten_db == $past(gain_atten_db) + 6'h01;
  endproperty
  a_attack: assert property (p_attack) else $error("attack step missing");
  property p_skip;
    zc_skip && !fb_off |-> fb_st_r == FB_IDLE || $past(fb_st_r) == FB_WAIT_ZC || $past(!zc_skip);
  endproperty
  a_skip: assert property (p_skip) else $error("waited for zero crossing while skipped");
  property p_warn_window;
    $rose(oc_warn[0]) |-> $past(win_end);
  endproperty
  a_warn_window: assert property (p_warn_window) else $error("warning changed off window edge");
  property p_hiz;
    |oc_fault |=> report.channels_hiz;
  endproperty
  a_hiz: assert property (p_hiz) else $error("fault without high impedance");
  c_pin_write: cover property (wr_stb && ptr_r == `FRTF_ADDR_PINCTL);
  c_oc_fault: cover property ($rose(oc_fault[0]));
  c_zc_apply: cover property (fb_st_r == FB_WAIT_ZC && zero_cross);
endmodule : frtf_top
`default_nettype wire

// *** inc/frtf_map.svh ***
// Register offsets, field positions, reset values and timing figures of the fault report block.
`ifndef FRTF_MAP_SVH
`define FRTF_MAP_SVH
`define FRTF_ADDR_MISC 8'h21
`define FRTF_ADDR_OCSTAT 8'h25
`define FRTF_ADDR_PINCTL 8'h27
`define FRTF_ADDR_FBCTL 8'h28
`define FRTF_MISC_RST 8'h00
`define FRTF_PINCTL_RST 8'h7f
`define FRTF_FBCTL_RST 8'h00
`define FRTF_MISC_CLR_BIT 7
`define FRTF_MISC_MASK_BIT 5
`define FRTF_PIN_RSV_BIT 7
`define FRTF_FB_ZC_MSB 7
`define FRTF_FB_ZC_LSB 6
`define FRTF_FB_BYPASS_BIT 5
`define FRTF_FB_ZCSKIP_BIT 4
`define FRTF_FB_ATK_MSB 3
`define FRTF_FB_ATK_LSB 2
`define FRTF_FB_REL_MSB 1
`define FRTF_FB_REL_LSB 0
`define FRTF_CLK_MHZ 125
`define FRTF_OC_WINDOW_MS 200
`define FRTF_OC_DENSITY_PCT 45
`define FRTF_OC_PERSIST_WIN 4
`define FRTF_ATK_BASE_MS 100
`define FRTF_REL_BASE_MS 200
`define FRTF_ZC_BASE_US 20
`endif

// *** inc/frtf_pkg.sv ***
// Types shared by the fault report and thermal foldback block.
package frtf_pkg;
  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic core_uv;
    logic core_por;
    logic clip;
    logic thermal;
  } frtf_cond_s;

  typedef struct packed {
    logic fault_pin;
    logic warn_pin;
    logic clip_pin;
    logic channels_hiz;
  } frtf_report_s;

  typedef enum logic [8:0] {
    I2C_IDLE = 9'h001, I2C_ADDR = 9'h002, I2C_AACK = 9'h004, I2C_REG = 9'h008, I2C_RACK = 9'h010,
    I2C_WDAT = 9'h020, I2C_WACK = 9'h040, I2C_TX = 9'h080, I2C_TXACK = 9'h100
  } frtf_i2c_e;

  typedef enum logic [1:0] {FB_IDLE = 2'h1, FB_WAIT_ZC = 2'h2} frtf_fb_e;
endpackage : frtf_pkg

// *** bench/testbench.sv ***
// Self-checking bench for the fault report and thermal foldback block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import frtf_pkg::*;
  localparam logic [6:0] DA = 7'h2a;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl = 1'b1;
  logic msda = 1'b1;
  logic zc = 1'b0;
  logic dens_on = 1'b0;
  logic [3:0] oc_base = 4'h0;
  logic [6:0] dcnt = 7'h00;
  logic [5:0] cv = 6'h00;
  logic [3:0] rv;
  logic [5:0] gain;
  logic sda_o;
  logic sda_oe_n;
  int n_fail = 0;
  int tests_run = 0;
  // The wire is low whenever either the bench or the device pulls it.
  wire sda = msda & (sda_oe_n | sda_o);
  // Channel one (bit 1) runs at 44 percent density, just under the warning threshold.
  wire [3:0] oc = oc_base | {2'b00, dens_on & (dcnt < 7'd44), 1'b0};
  always #4 clk = ~clk;
  always @(posedge clk) dcnt <= (dcnt == 7'd99) ? 7'h00 : dcnt + 7'h01;
  // A raised ceiling leaves room for every release step that the foldback test times.
  frtf_top #(.MAX_ATTEN(40), .OC_WINDOW_CYC(1000), .ATK_BASE_CYC(50), .REL_BASE_CYC(100), .ZC_BASE_CYC(10)) dut (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .oc_limit_flag(oc), .zero_cross(zc), .cond(frtf_cond_s'(cv)), .report(rv), .gain_atten_db(gain));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task automatic i2c_start;
    msda = 1'b1;
    tk(4);
    scl = 1'b1;
    tk(4);
    msda = 1'b0;
    tk(4);
    scl = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop;
    msda = 1'b0;
    tk(4);
    scl = 1'b1;
    tk(4);
    msda = 1'b1;
    tk(4);
  endtask : i2c_stop
  task automatic i2c_bit(input logic b, output logic r);
    msda = b;
    tk(4);
    scl = 1'b1;
    tk(2);
    r = sda;
    tk(2);
    scl = 1'b0;
  endtask : i2c_bit
  task automatic i2c_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(d[i], r);
      q[i] = r;
    end
    i2c_bit(1'b1, r);
    ack = ~r;
  endtask : i2c_byte
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    i2c_start();
    i2c_byte({DA, 1'b0}, q, k);
    i2c_byte(a, q, k);
    i2c_byte(d, q, k);
    i2c_stop();
  endtask : reg_wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic k;
    i2c_start();
    i2c_byte({DA, 1'b0}, q, k);
    i2c_byte(a, q, k);
    i2c_start();
    i2c_byte({DA, 1'b1}, q, k);
    i2c_byte(8'hff, q, k);
    i2c_stop();
    chk($sformatf("register %h", a), e, q);
  endtask : rdc
  task automatic t_regs;
    logic [7:0] q;
    logic k;
    rdc(8'h27, 8'h7f);
    rdc(8'h28, 8'h00);
    rdc(8'h25, 8'h00);
    rdc(8'h30, 8'h00);
    reg_wr(8'h27, 8'hff);
    rdc(8'h27, 8'h7f);
    reg_wr(8'h28, 8'he6);
    rdc(8'h28, 8'he6);
    reg_wr(8'h25, 8'hff);
    rdc(8'h25, 8'h00);
    reg_wr(8'h21, 8'h80);
    rdc(8'h21, 8'h00);
    i2c_start();
    i2c_byte({7'h2b, 1'b0}, q, k);
    i2c_stop();
    chk("foreign address ack", 16'h0, k);
    reg_wr(8'h28, 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic t_latch;
    int cb[5] = '{5, 4, 3, 2, 1};
    int pb[5] = '{3, 2, 2, 2, 1};
    int lb[5] = '{6, 2, 4, 3, 0};
    for (int m = 1; m >= 0; m--) begin
      for (int i = 0; i < 5; i++) begin
        reg_wr(8'h27, m[0] ? 8'h7f : 8'h7f & ~(8'h01 << lb[i]));
        cv[cb[i]] = 1'b1;
        tk(3);
        chk("report raised", 16'h1, rv[pb[i]]);
        cv[cb[i]] = 1'b0;
        tk(3);
        chk("report after drop", m[0], rv[pb[i]]);
        reg_wr(8'h21, 8'h80);
        tk(3);
        chk("report after clear", 16'h0, rv[pb[i]]);
      end
    end
    reg_wr(8'h27, 8'h7f);
    $display("test latching done");
  endtask : t_latch
  task automatic t_oc;
    oc_base = 4'h5;
    dens_on = 1'b1;
    tk(2100);
    rdc(8'h25, 8'h05);
    chk("fault and warn pins", 16'h1, {rv[3], rv[2]});
    reg_wr(8'h21, 8'ha0);
    tk(3);
    chk("masked warn pin", 16'h0, rv[2]);
    reg_wr(8'h21, 8'h00);
    tk(4000);
    rdc(8'h25, 8'h55);
    chk("fault pin and hi-z", 16'h3, {rv[3], rv[0]});
    oc_base = 4'h0;
    dens_on = 1'b0;
    tk(2200);
    rdc(8'h25, 8'h00);
    chk("held overcurrent reports", 16'h7, {rv[3], rv[2], rv[0]});
    reg_wr(8'h21, 8'h80);
    tk(3);
    chk("cleared overcurrent reports", 16'h0, {rv[3], rv[2], rv[0]});
    $display("test overcurrent done");
  endtask : t_oc
  task automatic meas(output int n);
    logic [5:0] g;
    g = gain;
    n = 0;
    while (gain === g && n < 5000) begin
      tk(1);
      n++;
    end
    if (n >= 5000) begin
      chk("gain step timeout", 16'h1, 16'h0);
      end_of_test();
    end
  endtask : meas
  // The first change only aligns to the step timer; the second is timed.
  task automatic step(input int e, input int d);
    int n;
    logic [5:0] g;
    meas(n);
    g = gain;
    meas(n);
    chk("step interval", e, (n >= e - 1 && n <= e + 2) ? e : n);
    chk("step size", g + d, gain);
  endtask : step
  task automatic t_fold;
    cv[0] = 1'b1;
    for (int c = 0; c < 4; c++) begin
      reg_wr(8'h28, 8'h10 | c[7:0] << 2);
      step(50 << c, 1);
    end
    reg_wr(8'h28, 8'h10);
    tk(1500);
    chk("attenuation ceiling", 16'd40, gain);
    cv[0] = 1'b0;
    for (int c = 0; c < 4; c++) begin
      reg_wr(8'h28, 8'h10 | c[7:0]);
      step(100 << c, -1);
      reg_wr(8'h28, c[7:0] << 6);
      step(100 + (10 << (2 * c)), -1);
    end
    zc = 1'b1;
    step(100, -1);
    cv[0] = 1'b1;
    step(50, 1);
    zc = 1'b0;
    reg_wr(8'h28, 8'h20);
    tk(300);
    chk("foldback disabled", 16'h0, gain);
    cv[0] = 1'b0;
    reg_wr(8'h28, 8'h00);
    $display("test foldback done");
  endtask : t_fold
  initial begin
    tk(6);
    rst = 1'b0;
    tk(2);
    t_regs();
    t_latch();
    t_oc();
    t_fold();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
